// *** logic/bsb_pkg.sv ***
// Function
// - Logic supply undervoltage pulls every high side down; low sides too, except in a slam or park brake phase or ovbrake_active outside normal mode
// - Bridge mode 00 or pump off discharges
// - Enabled overcurrent in normal mode discharges all but low sides in a slam brake phase
// - Supply overvoltage forces passive discharge
// - Pump undervoltage plus blanking holds discharge
// - Pump overtemperature forces passive discharge
// - Keep discharge after drain-source overvoltage handling
// - Non-normal modes discharge, braking low sides exempt
// - Slam brake honoured only in normal mode
// - Slam first actively turns off driven bridges
// - Slam then disables the charge pump
// - Slam routes brake input to low sides
// - Slam low sides follow brake level
// - Excluded low sides stay off in slam
// - Park brake on sleep/stop starts active turn-off
// - Park brake then disables the charge pump
// - Park brake frees low, keeps high pulldowns
// - Park brake low sides on when brake high
// - Gate level selects 11 V or 15 V target
// - Auto stage switches single/dual with supply hysteresis
// - Frequency modulation at 15.6 kHz when enabled
package bsb_pkg;
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MOD_FREQ_HZ = 15_600;
  localparam int unsigned MOD_HALF_CYC = CLK_HZ / (2 * MOD_FREQ_HZ);
  localparam logic [15:0] MOD_HALF_CNT = 16'(MOD_HALF_CYC);
  localparam int unsigned UV_BLANK_NS = 1000;
  localparam int unsigned UV_BLANK_CYC = (UV_BLANK_NS * 200 + 999) / 1000;
  localparam logic [15:0] UV_BLANK_CNT = 16'(UV_BLANK_CYC);
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_LS = 2'h1;
  localparam logic [1:0] MODE_HS = 2'h2;
  localparam logic [7:0] CCP_RST = 8'h10;
  localparam logic AUTO_STAGE_RST = 1'b0;
  localparam logic FMOD_RST = 1'b1;
  localparam logic GATE_LVL_RST = 1'b1;

  typedef enum logic [2:0] {
    BSB_OP_NORMAL, BSB_OP_INIT, BSB_OP_STOP, BSB_OP_FAILSAFE, BSB_OP_RESTART, BSB_OP_SLEEP
  } bsb_op_e;

  typedef enum {BSB_IDLE, BSB_TURNOFF, BSB_PUMPOFF, BSB_BRAKE} bsb_brk_e;

  typedef struct packed {
    logic logic_uv;
    logic vs_ov;
    logic vsint_ov;
    logic cp_uv;
    logic pump_overtemp_flag;
    logic csa_oc;
    logic [2:0] vds_ov_done;
    logic vs_above_hi;
    logic vs_below_lo;
  } bsb_fault_s;

  typedef struct packed {
    logic [5:0] half_bridge_mode_sel;
    logic pump_enable_bit;
    logic overcurrent_shutdown_enable;
    logic slam_brake;
    logic [2:0] slam_exclude;
    logic park_brake_enable;
    logic ovbrake_active;
    logic gate_level_select;
    logic auto_stage_select;
    logic pump_freq_modulation;
    logic [23:0] cross_conduction_time;
  } bsb_ctrl_s;

  typedef struct packed {
    logic [2:0] hs_pulldown;
    logic [2:0] ls_pulldown;
    logic [2:0] hs_active_off;
    logic [2:0] ls_active_off;
    logic [2:0] ls_brake_on;
    logic brake_override;
    logic pump_on;
    logic pump_normal_level;
    logic pump_single_stage;
    logic pump_fm_on;
    logic pump_fm_phase;
  } bsb_gate_s;
endpackage

// *** logic/bsb_sync.sv ***
`timescale 1ns/1ps
module bsb_sync (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic din,
  output logic dout
);
  import bsb_pkg::*;
  typedef struct packed {
    logic [2:0] sh;
    logic q;
  } bsb_sync_s;
  bsb_sync_s st;
  bsb_sync_s next_st;

  // Change taken only once stages two and three agree
  always_comb begin
    next_st = st;
    next_st.sh = {st.sh[1:0], din};
    if (st.sh[2] == st.sh[1]) begin
      next_st.q = st.sh[2];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign dout = st.q;
endmodule

// *** logic/bsb_cnt.sv ***
`timescale 1ns/1ps
module bsb_cnt (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic load,
  input wire logic [15:0] value,
  output logic busy
);
  import bsb_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
  } bsb_cnt_s;
  bsb_cnt_s st;
  bsb_cnt_s next_st;

  always_comb begin
    next_st = st;
    if (load) begin
      next_st.cnt = value;
    end else if (st.cnt != 16'h0000) begin
      next_st.cnt = st.cnt - 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign busy = (st.cnt != 16'h0000);
endmodule

// *** logic/bsb_top.sv ***
// Chosen here: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/1ps
module bsb_top (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic brake_level_input,
  input wire logic [2:0] op_mode,
  input wire bsb_pkg::bsb_fault_s faults,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output bsb_pkg::bsb_gate_s gate
);
  import bsb_pkg::*;

  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BRAKE = 12'h004;
  localparam logic [11:0] OFS_GENERAL_CONTROL_REG = 12'h008;
  localparam logic [11:0] OFS_CCP = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;

  typedef struct packed {
    bsb_ctrl_s ctrl;
    logic wr_pend;
    logic [11:0] wr_addr;
    logic [31:0] rdata;
    bsb_brk_e brk;
    logic park;
    logic [7:0] ccp_cnt;
    logic [15:0] fm_cnt;
    logic single;
    logic prev_cp_uv;
    logic prev_low_power;
    bsb_gate_s gate;
  } bsb_top_s;

  bsb_top_s st;
  bsb_top_s next_st;
  logic brk_sync;
  logic uv_blank;
  logic uv_fall;

  bsb_sync u_sync (
    .core_clk(core_clk),
    .nrst(nrst),
    .din(brake_level_input),
    .dout(brk_sync)
  );

  // Blanking restarts when pump undervoltage clears
  assign uv_fall = st.prev_cp_uv && !faults.cp_uv;
  bsb_cnt u_blank (
    .core_clk(core_clk),
    .nrst(nrst),
    .load(uv_fall),
    .value(UV_BLANK_CNT),
    .busy(uv_blank)
  );

  function automatic logic [31:0] reg_read(input bsb_top_s s, input logic [11:0] a, input bsb_fault_s f);
    logic [31:0] r;
    r = 32'h0000_0000;
    unique case (a)
      OFS_CTRL: r = {24'h0, s.ctrl.overcurrent_shutdown_enable, s.ctrl.pump_enable_bit,
                     s.ctrl.half_bridge_mode_sel};
      OFS_BRAKE: r = {26'h0, s.ctrl.ovbrake_active, s.ctrl.park_brake_enable, s.ctrl.slam_exclude,
                      s.ctrl.slam_brake};
      OFS_GENERAL_CONTROL_REG: r = {29'h0, s.ctrl.pump_freq_modulation, s.ctrl.auto_stage_select,
                        s.ctrl.gate_level_select};
      OFS_CCP: r = {8'h0, s.ctrl.cross_conduction_time};
      OFS_STATUS: r = {18'h0, 2'(s.brk), s.park, s.single, s.gate.pump_on, s.gate.brake_override,
                       f.cp_uv, f.pump_overtemp_flag, s.gate.hs_pulldown, s.gate.ls_pulldown};
      default: r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  always_comb begin
    logic take;
    logic normal;
    logic low_power;
    logic slam_go;
    logic [2:0] driven;
    logic [2:0] common_pd;
    logic [2:0] hs_pd;
    logic [2:0] ls_pd;
    logic ls_exempt;
    logic pump_cut;
    logic keep;
    bsb_brk_e cur;
    take = 1'b0;
    normal = 1'b0;
    low_power = 1'b0;
    slam_go = 1'b0;
    driven = 3'h0;
    common_pd = 3'h0;
    hs_pd = 3'h0;
    ls_pd = 3'h0;
    ls_exempt = 1'b0;
    pump_cut = 1'b0;
    keep = 1'b0;
    cur = BSB_IDLE;
    next_st = st;

    // Bus slave, zero wait states
    take = hsel && hready && htrans[1];
    next_st.wr_pend = take && hwrite;
    next_st.wr_addr = haddr[11:0];
    if (take && !hwrite) begin
      next_st.rdata = reg_read(st, haddr[11:0], faults);
    end
    if (st.wr_pend) begin
      unique case (st.wr_addr)
        OFS_CTRL: begin
          next_st.ctrl.half_bridge_mode_sel = hwdata[5:0];
          next_st.ctrl.pump_enable_bit = hwdata[6];
          next_st.ctrl.overcurrent_shutdown_enable = hwdata[7];
        end
        OFS_BRAKE: begin
          next_st.ctrl.slam_brake = hwdata[0];
          next_st.ctrl.slam_exclude = hwdata[3:1];
          next_st.ctrl.park_brake_enable = hwdata[4];
          next_st.ctrl.ovbrake_active = hwdata[5];
        end
        OFS_GENERAL_CONTROL_REG: begin
          next_st.ctrl.gate_level_select = hwdata[0];
          next_st.ctrl.auto_stage_select = hwdata[1];
          next_st.ctrl.pump_freq_modulation = hwdata[2];
        end
        OFS_CCP: next_st.ctrl.cross_conduction_time = hwdata[23:0];
        default: begin
        end
      endcase
    end

    normal = (op_mode == 3'(BSB_OP_NORMAL));
    low_power = (op_mode == 3'(BSB_OP_SLEEP)) || (op_mode == 3'(BSB_OP_STOP));
    next_st.prev_cp_uv = faults.cp_uv;
    next_st.prev_low_power = low_power;
    slam_go = normal && st.ctrl.slam_brake;

    for (int i = 0; i < 3; i++) begin
      driven[i] = (st.ctrl.half_bridge_mode_sel[2*i +: 2] == MODE_LS) ||
                  (st.ctrl.half_bridge_mode_sel[2*i +: 2] == MODE_HS);
    end

    // Brake sequencer shared by slam and parking entry
    unique case (st.brk)
      BSB_IDLE: begin
        if (slam_go) begin
          next_st.brk = BSB_TURNOFF;
          next_st.park = 1'b0;
          next_st.ccp_cnt = 8'h00;
        end else if (low_power && !st.prev_low_power && st.ctrl.park_brake_enable) begin
          next_st.brk = BSB_TURNOFF;
          next_st.park = 1'b1;
          next_st.ccp_cnt = 8'h00;
        end
      end
      BSB_TURNOFF: begin
        next_st.ccp_cnt = st.ccp_cnt + 8'h01;
        if (st.ccp_cnt >= st.ctrl.cross_conduction_time[7:0] &&
            st.ccp_cnt >= st.ctrl.cross_conduction_time[15:8] &&
            st.ccp_cnt >= st.ctrl.cross_conduction_time[23:16]) begin
          next_st.brk = BSB_PUMPOFF;
        end
      end
      BSB_PUMPOFF: next_st.brk = BSB_BRAKE;
      BSB_BRAKE: begin
      end
    endcase
    // Leaving the triggering condition aborts the sequence; gates drop it in that same cycle
    keep = st.park ? low_power : slam_go;
    if (keep) begin
      cur = st.brk;
    end else if (st.brk != BSB_IDLE) begin
      next_st.brk = BSB_IDLE;
    end

    pump_cut = (cur == BSB_PUMPOFF) || (cur == BSB_BRAKE);

    for (int i = 0; i < 3; i++) begin
      next_st.gate.hs_active_off[i] = 1'b0;
      next_st.gate.ls_active_off[i] = 1'b0;
      if (cur == BSB_TURNOFF && driven[i] &&
          st.ccp_cnt < st.ctrl.cross_conduction_time[8*i +: 8]) begin
        next_st.gate.hs_active_off[i] = 1'b1;
        next_st.gate.ls_active_off[i] = 1'b1;
      end
      next_st.gate.ls_brake_on[i] = 1'b0;
      if (cur == BSB_BRAKE) begin
        // Excluded low sides are held off in slam only; park braking ignores the exclusion
        next_st.gate.ls_brake_on[i] = brk_sync &&
                                      !(st.park ? 1'b0 : st.ctrl.slam_exclude[i]);
      end
    end
    next_st.gate.brake_override = (cur == BSB_BRAKE) && !st.park;

    // Causes shared by the high and low side of each bridge, some of them per bridge
    for (int i = 0; i < 3; i++) begin
      common_pd[i] = faults.logic_uv ||
                     (normal && st.ctrl.half_bridge_mode_sel[2*i +: 2] == MODE_OFF) ||
                     (normal && !st.ctrl.pump_enable_bit) ||
                     (normal && faults.csa_oc && st.ctrl.overcurrent_shutdown_enable) ||
                     faults.vs_ov || faults.vsint_ov ||
                     faults.cp_uv || uv_fall || uv_blank ||
                     faults.pump_overtemp_flag ||
                     (normal && faults.vds_ov_done[i]) ||
                     !normal;
    end
    ls_exempt = (st.park && cur == BSB_BRAKE) || st.ctrl.ovbrake_active;
    hs_pd = common_pd;
    ls_pd = (ls_exempt && !normal) ? 3'h0 : common_pd;
    if (cur == BSB_BRAKE && !st.park) begin
      ls_pd = 3'h0;
    end
    next_st.gate.hs_pulldown = hs_pd;
    next_st.gate.ls_pulldown = ls_pd & ~next_st.gate.ls_brake_on;

    next_st.gate.pump_on = st.ctrl.pump_enable_bit && !pump_cut;
    next_st.gate.pump_normal_level = st.ctrl.gate_level_select;

    // Stage selection with supply hysteresis
    if (!st.ctrl.auto_stage_select) begin
      next_st.single = 1'b0;
    end else if (faults.vs_above_hi) begin
      next_st.single = 1'b1;
    end else if (faults.vs_below_lo) begin
      next_st.single = 1'b0;
    end
    next_st.gate.pump_single_stage = next_st.single;

    // Modulation square wave, half period counted in core cycles
    next_st.gate.pump_fm_on = st.ctrl.pump_freq_modulation;
    if (!st.ctrl.pump_freq_modulation) begin
      next_st.fm_cnt = 16'h0000;
      next_st.gate.pump_fm_phase = 1'b0;
    end else if (st.fm_cnt >= MOD_HALF_CNT - 16'h0001) begin
      next_st.fm_cnt = 16'h0000;
      next_st.gate.pump_fm_phase = !st.gate.pump_fm_phase;
    end else begin
      next_st.fm_cnt = st.fm_cnt + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!nrst) begin
      st <= '0;
      st.ctrl.cross_conduction_time <= {CCP_RST, CCP_RST, CCP_RST};
      st.ctrl.auto_stage_select <= AUTO_STAGE_RST;
      st.ctrl.pump_freq_modulation <= FMOD_RST;
      st.ctrl.gate_level_select <= GATE_LVL_RST;
      st.brk <= BSB_IDLE;
      // Safe state from reset: every gate pulled down
      st.gate.hs_pulldown <= 3'h7;
      st.gate.ls_pulldown <= 3'h7;
    end else begin
      st <= next_st;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = st.rdata;
  assign gate = st.gate;
endmodule

// *** test/bsb_chk_assertions.sv ***
`timescale 1ns/1ps
module bsb_chk
  import bsb_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic [2:0] op_mode,
  input wire bsb_pkg::bsb_fault_s faults,
  input wire bsb_pkg::bsb_gate_s gate
);
  logic [15:0] fm_cnt;
  default clocking @(posedge core_clk);
  endclocking
  default disable iff (!nrst);
  // Cycles since the last modulation edge, cleared while modulation is off
  always_ff @(posedge core_clk) begin
    if (!nrst || !gate.pump_fm_on || $changed(gate.pump_fm_phase)) begin
      fm_cnt <= 16'h0;
    end else begin
      fm_cnt <= fm_cnt + 16'h1;
    end
  end
  property p_uv;
    faults.logic_uv |=> gate.hs_pulldown == 3'h7 && gate.ls_pulldown == 3'h7;
  endproperty
  a_uv: assert property (p_uv) else $error("supply low without pulldown");
  property p_ov;
    (faults.vs_ov || faults.vsint_ov) |=> gate.hs_pulldown == 3'h7;
  endproperty
  a_ov: assert property (p_ov) else $error("overvoltage without pulldown");
  property p_cpuv;
    $fell(faults.cp_uv) |-> (gate.hs_pulldown == 3'h7) [*8];
  endproperty
  a_cpuv: assert property (p_cpuv) else $error("pump blanking cut short");
  property p_ot;
    faults.pump_overtemp_flag |=> gate.hs_pulldown == 3'h7;
  endproperty
  a_ot: assert property (p_ot) else $error("pump hot without pulldown");
  property p_mode;
    op_mode != 3'h0 |=> gate.hs_pulldown == 3'h7;
  endproperty
  a_mode: assert property (p_mode) else $error("high side free outside normal");
  property p_slam_mode;
    op_mode != 3'h0 |=> !gate.brake_override;
  endproperty
  a_slam_mode: assert property (p_slam_mode) else $error("slam outside normal");
  property p_slam_pump;
    gate.brake_override |-> !gate.pump_on;
  endproperty
  a_slam_pump: assert property (p_slam_pump) else $error("pump on during slam");
  property p_ls_rel;
    gate.ls_brake_on != 3'h0 |-> (gate.ls_brake_on & gate.ls_pulldown) == 3'h0;
  endproperty
  a_ls_rel: assert property (p_ls_rel) else $error("braking low side pulled down");
  property p_fm;
    gate.pump_fm_on |-> fm_cnt <= MOD_HALF_CNT;
  endproperty
  a_fm: assert property (p_fm) else $error("modulation half period too long");
endmodule
bind bsb_top bsb_chk u_chk (.core_clk(core_clk), .nrst(nrst), .op_mode(op_mode), .faults(faults), .gate(gate));

// *** test/bsb_host_pwm.sv ***
`timescale 1ns/1ps
module bsb_host_pwm (
  input wire logic core_clk,
  input wire logic level_req,
  output logic brake_pin
);
  // Edges land off the clock so the device sees a truly asynchronous pin
  initial brake_pin = 1'b0;
  always @(posedge core_clk) begin
    brake_pin <= #1.3 level_req;
  end
endmodule

// *** test/bsb_top_tb.sv ***
`timescale 1ns/1ps
module bsb_top_tb;
  import bsb_pkg::*;
  typedef struct packed {
    logic [2:0] op;
    logic [10:0] flt;
    logic [7:0] ctrl;
    logic [2:0] hs;
    logic [2:0] ls;
  } bsb_row_s;
  logic core_clk = 1'b0;
  logic nrst = 1'b0;
  logic pin_req = 1'b0;
  logic brake_pin;
  logic [2:0] op_mode = 3'h0;
  bsb_fault_s faults = '0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  bsb_gate_s gate;
  int fails = 0;
  int checks_done = 0;
  logic [31:0] rdv;
  int cyc;
  logic fm_ph;
  bsb_row_s rows [15];
  always #2.5 core_clk = ~core_clk;
  bsb_host_pwm u_pwm (.core_clk(core_clk), .level_req(pin_req), .brake_pin(brake_pin));
  bsb_top dut (.core_clk(core_clk), .nrst(nrst), .brake_level_input(brake_pin), .op_mode(op_mode),
    .faults(faults), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .gate(gate));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // Single word transfer; waits on the slave's ready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdv = hrdata;
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge core_clk);
    fails++;
    final_report();
  end
  initial begin
    rows = '{
      '{3'h0, 11'h000, 8'hd5, 3'h0, 3'h0},
      '{3'h0, 11'h400, 8'hd5, 3'h7, 3'h7},
      '{3'h0, 11'h200, 8'hd5, 3'h7, 3'h7},
      '{3'h0, 11'h100, 8'hd5, 3'h7, 3'h7},
      '{3'h0, 11'h040, 8'hd5, 3'h7, 3'h7},
      '{3'h0, 11'h020, 8'hd5, 3'h7, 3'h7},
      '{3'h0, 11'h020, 8'h55, 3'h0, 3'h0},
      '{3'h0, 11'h008, 8'hd5, 3'h2, 3'h2},
      '{3'h0, 11'h000, 8'hd1, 3'h2, 3'h2},
      '{3'h0, 11'h000, 8'h95, 3'h7, 3'h7},
      '{3'h1, 11'h000, 8'hd5, 3'h7, 3'h7},
      '{3'h2, 11'h000, 8'hd5, 3'h7, 3'h7},
      '{3'h3, 11'h000, 8'hd5, 3'h7, 3'h7},
      '{3'h4, 11'h000, 8'hd5, 3'h7, 3'h7},
      '{3'h5, 11'h000, 8'hd5, 3'h7, 3'h7}};
    w(6);
    chk("rst pd", {26'h0, gate.hs_pulldown, gate.ls_pulldown}, 32'h3f);
    nrst <= 1'b1;
    w(1);
    bus(1'b0, 32'h8, 32'h0);
    chk("general_control_reg", rdv, 32'h5);
    bus(1'b0, 32'h100, 32'h0);
    chk("unmapped", rdv, 32'h0);
    chk("resp", {31'h0, hresp}, 32'h0);
    $display("test reset done");
    foreach (rows[i]) begin
      bus(1'b1, 32'h0, {24'h0, rows[i].ctrl});
      op_mode <= rows[i].op;
      faults <= bsb_fault_s'(rows[i].flt);
      w(4);
      chk("pd", {26'h0, gate.hs_pulldown, gate.ls_pulldown}, {26'h0, rows[i].hs, rows[i].ls});
    end
    op_mode <= 3'h0;
    faults <= bsb_fault_s'(11'h080);
    w(5);
    faults <= '0;
    w(190);
    chk("blank", {29'h0, gate.hs_pulldown}, 32'h7);
    w(25);
    chk("blank end", {29'h0, gate.hs_pulldown}, 32'h0);
    $display("test table done");
    chk("lvl", {31'h0, gate.pump_normal_level}, 32'h1);
    // Half period measured between two phase edges
    @(gate.pump_fm_phase);
    fm_ph = gate.pump_fm_phase;
    cyc = 0;
    while (gate.pump_fm_phase === fm_ph) begin
      w(1);
      cyc++;
    end
    chk("fm half", cyc, MOD_HALF_CYC);
    chk("fm", {31'h0, gate.pump_fm_on}, 32'h1);
    bus(1'b1, 32'h8, 32'h2);
    faults <= bsb_fault_s'(11'h002);
    w(4);
    chk("lvl", {30'h0, gate.pump_normal_level, gate.pump_fm_on}, 32'h0);
    chk("single", {31'h0, gate.pump_single_stage}, 32'h1);
    faults <= bsb_fault_s'(11'h001);
    w(4);
    chk("dual", {31'h0, gate.pump_single_stage}, 32'h0);
    bus(1'b1, 32'h8, 32'h5);
    faults <= bsb_fault_s'(11'h002);
    w(4);
    chk("no auto", {31'h0, gate.pump_single_stage}, 32'h0);
    faults <= '0;
    $display("test pump done");
    bus(1'b1, 32'h4, 32'h1);
    w(3);
    chk("slam off", {31'h0, |(gate.hs_active_off | gate.ls_active_off)}, 32'h1);
    w(40);
    chk("slam", {30'h0, gate.brake_override, gate.pump_on}, 32'h2);
    pin_req <= 1'b1;
    w(10);
    chk("slam ls", {29'h0, gate.ls_brake_on}, 32'h7);
    bus(1'b1, 32'h4, 32'h3);
    w(10);
    chk("exclude", {29'h0, gate.ls_brake_on}, 32'h6);
    pin_req <= 1'b0;
    w(10);
    chk("slam low", {29'h0, gate.ls_brake_on}, 32'h0);
    op_mode <= 3'h1;
    w(3);
    chk("slam mode", {31'h0, gate.brake_override}, 32'h0);
    op_mode <= 3'h0;
    bus(1'b1, 32'h4, 32'h10);
    $display("test slam done");
    pin_req <= 1'b1;
    w(10);
    op_mode <= 3'h2;
    w(3);
    chk("park off", {31'h0, |(gate.hs_active_off | gate.ls_active_off)}, 32'h1);
    w(40);
    chk("park pump", {31'h0, gate.pump_on}, 32'h0);
    chk("park pd", {26'h0, gate.hs_pulldown, gate.ls_pulldown}, 32'h38);
    chk("park ls", {29'h0, gate.ls_brake_on}, 32'h7);
    op_mode <= 3'h0;
    $display("test park done");
    final_report();
  end
endmodule
